/* File: rtl/recorder_trigger_and_status.sv */
// Recorder trigger combination, logging control and status word publication
//
// Overview of operation
// - Logging starts only when both trigger unit results are active, combined by AND.
// - With both units disabled the combined trigger is held inactive.
// - With one unit disabled, that unit counts as always active so the enabled one decides.
// - Each unit takes only a 16-bit acquisition parameter as its source.
// - A 16-bit status word is published as an acquisition parameter.
// - Status word holds error code in bits 0-5, full/recording/idle in 6-8, fill level in 9-15.
// - The recording bit is set only after the first complete block has been stored.
// - In digital mode each parameter bit is compared with a one, zero or don't-care mask.
// - Digital bit matches are ANDed by default, or ORed when so configured.
// - A finished period with the trigger still active starts another equal period.
// - At least two blocks are recorded once triggered, unless the card becomes full first.
`timescale 1ns/1ps
`default_nettype none

module recorder_trigger_and_status
    import rec_pkg::*;
(
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire rec_pkg::apb_req_t     apb_req,
    output var  rec_pkg::apb_rsp_t     apb_rsp,
    input  wire logic                  acq_cycle,
    input  wire rec_pkg::param_word_t  trig_param_a,
    input  wire rec_pkg::param_word_t  trig_param_b,
    input  wire logic                  block_written,
    input  wire logic                  card_full,
    input  wire logic [rec_pkg::ERR_W-1:0]  error_code,
    input  wire logic [rec_pkg::FILL_W-1:0] fill_level,
    output var  rec_pkg::status_word_t status_word,
    output logic                       combined_trigger,
    output logic                       logging_active,
    output logic                       irq
);
    import rec_pkg::*;

    // ****************************************
    // Trigger evaluation helpers
    // ****************************************
    function automatic logic unit_eval(input trig_cfg_t cfg, input param_word_t p);
        param_word_t eq;
        logic        dig;
        eq = ~(p ^ cfg.value);
        if (cfg.or_bits) begin
            dig = (|(cfg.care & eq)) | (cfg.care == CARE_RESET);
        end else begin
            dig = &(~cfg.care | eq);
        end
        if (cfg.analog_mode) begin
            unit_eval = (p >= cfg.low) && (p <= cfg.high);
        end else begin
            unit_eval = dig;
        end
    endfunction

    function automatic logic unit_term(input trig_cfg_t cfg, input logic hit);
        unit_term = cfg.enable ? hit : 1'b1;
    endfunction

    // ****************************************
    // Registers
    // ****************************************
    trig_cfg_t          cfg_ff [NUM_UNITS];
    param_word_t        blocks_ff;
    logic [IRQ_W-1:0]   irq_status_ff;
    logic [IRQ_W-1:0]   irq_enable_ff;
    logic [IRQ_W-1:0]   irq_event;
    logic [IRQ_W-1:0]   irq_clear;
    logic               irq_ff;
    rec_state_t         state_ff;
    rec_state_t         nxt_state;
    param_word_t        blk_cnt_ff;
    param_word_t        nxt_blk_cnt;
    logic               first_block_ff;
    logic               nxt_first_block;
    logic               logging_ff;
    logic               combined_ff;
    logic               nxt_combined;
    status_word_t       status_ff;
    param_word_t        period_len;
    param_word_t        trig_param [NUM_UNITS];
    logic [NUM_UNITS-1:0] unit_hit;
    apb_rsp_t           rsp_ff;
    logic [DATA_W-1:0]  rd_data;
    logic               rd_mapped;
    logic               wr_en;

    assign trig_param[0] = trig_param_a;
    assign trig_param[1] = trig_param_b;

    // ****************************************
    // Trigger units and combination
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < NUM_UNITS; gi++) begin : g_unit
            assign unit_hit[gi] = unit_eval(cfg_ff[gi], trig_param[gi]);
        end
    endgenerate

    always_comb begin
        if (!cfg_ff[0].enable && !cfg_ff[1].enable) begin
            nxt_combined = 1'b0;
        end else begin
            nxt_combined = unit_term(cfg_ff[0], unit_hit[0]) &
                           unit_term(cfg_ff[1], unit_hit[1]);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            combined_ff <= 1'b0;
        end else if (acq_cycle) begin
            combined_ff <= nxt_combined;
        end
    end

    // ****************************************
    // Logging control
    // ****************************************
    assign period_len = (blocks_ff < MIN_BLOCKS) ? MIN_BLOCKS : blocks_ff;

    always_comb begin
        nxt_state       = state_ff;
        nxt_blk_cnt     = blk_cnt_ff;
        nxt_first_block = first_block_ff;
        irq_event       = IRQ_RESET;
        unique case (state_ff)
            ST_IDLE: begin
                if (acq_cycle && card_full) begin
                    nxt_state               = ST_FULL;
                    irq_event[IRQ_FULL_BIT] = 1'b1;
                end else if (acq_cycle && nxt_combined) begin
                    nxt_state                = ST_LOG;
                    nxt_blk_cnt              = '0;
                    nxt_first_block          = 1'b0;
                    irq_event[IRQ_START_BIT] = 1'b1;
                end
            end
            ST_LOG: begin
                if (card_full) begin
                    nxt_state               = ST_FULL;
                    irq_event[IRQ_FULL_BIT] = 1'b1;
                end else if (block_written) begin
                    nxt_first_block = 1'b1;
                    if (blk_cnt_ff + 16'h0001 >= period_len) begin
                        nxt_blk_cnt = '0;
                        if (!combined_ff) begin
                            nxt_state               = ST_IDLE;
                            irq_event[IRQ_STOP_BIT] = 1'b1;
                        end
                    end else begin
                        nxt_blk_cnt = blk_cnt_ff + 16'h0001;
                    end
                end
            end
            ST_FULL: begin
                if (!card_full) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff       <= ST_IDLE;
            blk_cnt_ff     <= '0;
            first_block_ff <= 1'b0;
            logging_ff     <= 1'b0;
        end else begin
            state_ff       <= nxt_state;
            blk_cnt_ff     <= nxt_blk_cnt;
            first_block_ff <= nxt_first_block;
            logging_ff     <= (nxt_state == ST_LOG);
        end
    end

    // ****************************************
    // Status word
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_ff <= STATUS_RESET;
        end else if (acq_cycle) begin
            status_ff.err       <= error_code;
            status_ff.full      <= (state_ff == ST_FULL);
            status_ff.recording <= (state_ff == ST_LOG) && first_block_ff;
            status_ff.idle      <= (state_ff == ST_IDLE);
            status_ff.fill      <= fill_level;
        end
    end

    // ****************************************
    // Interrupts
    // ****************************************
    assign irq_clear = (wr_en && apb_req.paddr == OFS_IRQ_CLEAR) ?
                       apb_req.pwdata[IRQ_W-1:0] : IRQ_RESET;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_ff <= IRQ_RESET;
            irq_ff        <= 1'b0;
        end else begin
            irq_status_ff <= (irq_status_ff & ~irq_clear) | irq_event;
            irq_ff        <= |(((irq_status_ff & ~irq_clear) | irq_event) & irq_enable_ff);
        end
    end

    // ****************************************
    // APB slave
    // ****************************************
    assign wr_en = apb_req.psel && apb_req.penable && rsp_ff.pready && apb_req.pwrite;

    always_comb begin
        rd_data   = '0;
        rd_mapped = 1'b1;
        unique case (apb_req.paddr)
            OFS_CTRL: begin
                for (int u = 0; u < NUM_UNITS; u++) begin
                    rd_data[u*CTRL_UNIT_STRIDE+CTRL_EN_BIT]     = cfg_ff[u].enable;
                    rd_data[u*CTRL_UNIT_STRIDE+CTRL_ANALOG_BIT] = cfg_ff[u].analog_mode;
                    rd_data[u*CTRL_UNIT_STRIDE+CTRL_OR_BIT]     = cfg_ff[u].or_bits;
                end
            end
            OFS_BOUNDS_A:   rd_data = {cfg_ff[0].high, cfg_ff[0].low};
            OFS_MASK_A:     rd_data = {cfg_ff[0].value, cfg_ff[0].care};
            OFS_BOUNDS_B:   rd_data = {cfg_ff[1].high, cfg_ff[1].low};
            OFS_MASK_B:     rd_data = {cfg_ff[1].value, cfg_ff[1].care};
            OFS_BLOCKS:     rd_data[PARAM_W-1:0] = blocks_ff;
            OFS_STATUS:     rd_data[PARAM_W-1:0] = status_ff;
            OFS_IRQ_STATUS: rd_data[IRQ_W-1:0] = irq_status_ff;
            OFS_IRQ_ENABLE: rd_data[IRQ_W-1:0] = irq_enable_ff;
            OFS_IRQ_CLEAR:  rd_data = '0;
            default:        rd_mapped = 1'b0;
        endcase
    end

    // Answer in the first access cycle; data captured in setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rsp_ff <= '0;
        end else begin
            rsp_ff.pready <= apb_req.psel && !apb_req.penable;
            if (apb_req.psel && !apb_req.penable) begin
                rsp_ff.prdata  <= apb_req.pwrite ? '0 : rd_data;
                rsp_ff.pslverr <= !rd_mapped;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int u = 0; u < NUM_UNITS; u++) begin
                cfg_ff[u] <= '{enable: 1'b0, analog_mode: 1'b0, or_bits: 1'b0,
                               low: LOW_RESET, high: HIGH_RESET,
                               care: CARE_RESET, value: VALUE_RESET};
            end
            blocks_ff     <= BLOCKS_RESET;
            irq_enable_ff <= IRQ_RESET;
        end else if (wr_en) begin
            unique case (apb_req.paddr)
                OFS_CTRL: begin
                    for (int u = 0; u < NUM_UNITS; u++) begin
                        cfg_ff[u].enable      <= apb_req.pwdata[u*CTRL_UNIT_STRIDE+CTRL_EN_BIT];
                        cfg_ff[u].analog_mode <= apb_req.pwdata[u*CTRL_UNIT_STRIDE+CTRL_ANALOG_BIT];
                        cfg_ff[u].or_bits     <= apb_req.pwdata[u*CTRL_UNIT_STRIDE+CTRL_OR_BIT];
                    end
                end
                OFS_BOUNDS_A: begin
                    cfg_ff[0].low  <= apb_req.pwdata[LOW_LSB+:PARAM_W];
                    cfg_ff[0].high <= apb_req.pwdata[HIGH_LSB+:PARAM_W];
                end
                OFS_MASK_A: begin
                    cfg_ff[0].care  <= apb_req.pwdata[LOW_LSB+:PARAM_W];
                    cfg_ff[0].value <= apb_req.pwdata[HIGH_LSB+:PARAM_W];
                end
                OFS_BOUNDS_B: begin
                    cfg_ff[1].low  <= apb_req.pwdata[LOW_LSB+:PARAM_W];
                    cfg_ff[1].high <= apb_req.pwdata[HIGH_LSB+:PARAM_W];
                end
                OFS_MASK_B: begin
                    cfg_ff[1].care  <= apb_req.pwdata[LOW_LSB+:PARAM_W];
                    cfg_ff[1].value <= apb_req.pwdata[HIGH_LSB+:PARAM_W];
                end
                OFS_BLOCKS:     blocks_ff <= apb_req.pwdata[PARAM_W-1:0];
                OFS_IRQ_ENABLE: irq_enable_ff <= apb_req.pwdata[IRQ_W-1:0];
                default: begin
                end
            endcase
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign apb_rsp          = rsp_ff;
    assign status_word      = status_ff;
    assign combined_trigger = combined_ff;
    assign logging_active   = logging_ff;
    assign irq              = irq_ff;

endmodule

`default_nettype wire

/* File: rtl/rec_pkg.sv */
// Constants, types and register map of the recorder trigger and status block
package rec_pkg;

    // ****************************************
    // Widths
    // ****************************************
    localparam int unsigned PARAM_W     = 16;
    localparam int unsigned ADDR_W      = 8;
    localparam int unsigned DATA_W      = 32;
    localparam int unsigned NUM_UNITS   = 2;
    localparam int unsigned ERR_W       = 6;
    localparam int unsigned FILL_W      = 7;
    localparam int unsigned IRQ_W       = 3;

    // ****************************************
    // Register byte offsets
    // ****************************************
    localparam logic [ADDR_W-1:0] OFS_CTRL       = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_BOUNDS_A   = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_MASK_A     = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_BOUNDS_B   = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_MASK_B     = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_BLOCKS     = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_STATUS     = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR  = 8'h24;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int unsigned CTRL_EN_BIT      = 0;
    localparam int unsigned CTRL_ANALOG_BIT  = 1;
    localparam int unsigned CTRL_OR_BIT      = 2;
    localparam int unsigned CTRL_UNIT_STRIDE = 8;
    localparam int unsigned LOW_LSB          = 0;
    localparam int unsigned HIGH_LSB         = 16;
    localparam int unsigned IRQ_START_BIT    = 0;
    localparam int unsigned IRQ_STOP_BIT     = 1;
    localparam int unsigned IRQ_FULL_BIT     = 2;

    // ****************************************
    // Reset values and counts
    // ****************************************
    localparam logic [PARAM_W-1:0] LOW_RESET    = 16'h0000;
    localparam logic [PARAM_W-1:0] HIGH_RESET   = 16'hFFFF;
    localparam logic [PARAM_W-1:0] CARE_RESET   = 16'h0000;
    localparam logic [PARAM_W-1:0] VALUE_RESET  = 16'h0000;
    localparam logic [PARAM_W-1:0] BLOCKS_RESET = 16'h000A;
    localparam logic [PARAM_W-1:0] MIN_BLOCKS   = 16'h0002;
    localparam logic [PARAM_W-1:0] STATUS_RESET = 16'h0100;
    localparam logic [IRQ_W-1:0]   IRQ_RESET    = 3'h0;

    // ****************************************
    // Types
    // ****************************************
    typedef logic [PARAM_W-1:0] param_word_t;

    typedef struct packed {
        logic        enable;
        logic        analog_mode;
        logic        or_bits;
        param_word_t low;
        param_word_t high;
        param_word_t care;
        param_word_t value;
    } trig_cfg_t;

    typedef struct packed {
        logic [FILL_W-1:0] fill;
        logic              idle;
        logic              recording;
        logic              full;
        logic [ERR_W-1:0]  err;
    } status_word_t;

    typedef struct packed {
        logic [ADDR_W-1:0] paddr;
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [DATA_W-1:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [DATA_W-1:0] prdata;
        logic              pready;
        logic              pslverr;
    } apb_rsp_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_LOG  = 3'b010,
        ST_FULL = 3'b100
    } rec_state_t;

endpackage

/* File: tb/rec_checker_assertions.sv */
// Port-level assertions for the recorder trigger and status block
`timescale 1ns/1ps
`default_nettype none
module rec_checker
    import rec_pkg::*;
(
    input wire logic                   pclk,
    input wire logic                   presetn,
    input wire rec_pkg::apb_req_t      apb_req,
    input wire rec_pkg::apb_rsp_t      apb_rsp,
    input wire logic                   acq_cycle,
    input wire rec_pkg::param_word_t   trig_param_a,
    input wire rec_pkg::param_word_t   trig_param_b,
    input wire logic                   block_written,
    input wire logic                   card_full,
    input wire logic [rec_pkg::ERR_W-1:0]  error_code,
    input wire logic [rec_pkg::FILL_W-1:0] fill_level,
    input wire rec_pkg::status_word_t  status_word,
    input wire logic                   combined_trigger,
    input wire logic                   logging_active,
    input wire logic                   irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic       seen_ff;
    logic [1:0] cnt_ff;
    // Block seen and saturating block count of the current logging run
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen_ff <= 1'b0;
            cnt_ff  <= 2'h0;
        end else begin
            seen_ff <= logging_active & (seen_ff | block_written);
            cnt_ff  <= !logging_active ? 2'h0 : (cnt_ff == 2'h2) ? cnt_ff : cnt_ff + {1'b0, block_written};
        end
    end
    sequence s_setup;
        apb_req.psel && !apb_req.penable;
    endsequence
    property p_ready;
        s_setup |=> apb_rsp.pready ##1 !apb_rsp.pready;
    endproperty
    a_ready: assert property (p_ready) else $error("pready not a single access cycle");
    property p_slverr;
        s_setup ##0 (apb_req.paddr > 8'h24) |=> apb_rsp.pslverr && apb_rsp.prdata == 32'h0;
    endproperty
    a_slverr: assert property (p_slverr) else $error("unmapped access not refused");
    property p_start;
        $rose(logging_active) |-> combined_trigger && $past(acq_cycle);
    endproperty
    a_start: assert property (p_start) else $error("logging began without trigger");
    property p_comb_acq;
        $changed(combined_trigger) |-> $past(acq_cycle);
    endproperty
    a_comb_acq: assert property (p_comb_acq) else $error("trigger moved off cycle");
    property p_status_hold;
        !$past(acq_cycle) |-> $stable(status_word);
    endproperty
    a_status_hold: assert property (p_status_hold) else $error("status moved off cycle");
    property p_status_copy;
        acq_cycle |=> status_word.err == $past(error_code) && status_word.fill == $past(fill_level);
    endproperty
    a_status_copy: assert property (p_status_copy) else $error("status fields wrong");
    property p_rec;
        $rose(status_word.recording) |-> $past(seen_ff) && $past(acq_cycle, 2) == 1'b0;
    endproperty
    a_rec: assert property (p_rec) else $error("recording shown before a block");
    property p_min;
        $fell(logging_active) && !$past(card_full) |-> cnt_ff == 2'h2;
    endproperty
    a_min: assert property (p_min) else $error("logging stopped under two blocks");
    property p_quiet;
        !logging_active && !status_word.full ##1 !$past(acq_cycle) |-> !logging_active;
    endproperty
    a_quiet: assert property (p_quiet) else $error("logging began off cycle");
endmodule
`default_nettype wire

/* File: tb/rec_backplane.sv */
// Backplane partner: acquisition pulses, stored-block pulses, trigger parameters
`timescale 1ns/1ps
`default_nettype none
module rec_backplane #(
    parameter int ACQ_GAP = 7,
    parameter int BLK_GAP = 5
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          run,
    input  wire logic          switch_pin,
    input  wire rec_pkg::param_word_t raw_a,
    input  wire rec_pkg::param_word_t raw_b,
    output logic               acq_cycle,
    output logic               block_written,
    output rec_pkg::param_word_t trig_param_a,
    output rec_pkg::param_word_t trig_param_b
);
    int acq_cnt;
    int blk_cnt;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acq_cnt       <= 0;
            blk_cnt       <= 0;
            acq_cycle     <= 1'b0;
            block_written <= 1'b0;
        end else begin
            acq_cnt       <= run ? (acq_cnt + 1) % ACQ_GAP : 0;
            blk_cnt       <= run ? (blk_cnt + 1) % BLK_GAP : 0;
            acq_cycle     <= run && acq_cnt == ACQ_GAP - 1;
            block_written <= run && blk_cnt == BLK_GAP - 1;
        end
    end
    // Both sources reach the recorder undelayed
    assign trig_param_a = raw_a;
    // Switch level mirrored into the controller word
    assign trig_param_b = {raw_b[15:1], switch_pin};
endmodule
`default_nettype wire

/* File: tb/recorder_trigger_and_status_bench.sv */
// Self-checking bench for the recorder trigger and status block
`timescale 1ns/1ps
`default_nettype none
module recorder_trigger_and_status_bench;
    import rec_pkg::*;
    logic              pclk;
    logic              presetn;
    logic              run;
    logic              switch_pin;
    logic              card_full;
    apb_req_t          apb_req;
    apb_rsp_t          apb_rsp;
    logic              acq_cycle;
    logic              block_written;
    param_word_t       trig_param_a;
    param_word_t       trig_param_b;
    param_word_t       raw_a;
    param_word_t       raw_b;
    logic [ERR_W-1:0]  error_code;
    logic [FILL_W-1:0] fill_level;
    status_word_t      status_word;
    logic              combined_trigger;
    logic              logging_active;
    logic              irq;
    int                fail_count;
    int                n_checks;
    int                ctrl;
    int                st;
    int                nxt;
    int                cnt;
    int                irq_st;
    int                i;
    int                ctrls [6] = '{'h000, 'h001, 'h100, 'h005, 'h203, 'h101};
    logic [31:0]       rst_val [11] = '{0, 'hFFFF0000, 0, 'hFFFF0000, 0, 'hA, 'h100, 0, 0, 0, 0};
    logic [31:0]       bnd [2] = '{32'h8000_1000, 32'hC000_4000};
    logic [31:0]       msk [2] = '{32'h0050_00F0, 32'h0001_0001};
    logic [31:0]       rd;
    logic              er;
    logic              rec_ok;
    logic              comb_q;
    logic              pend;
    logic [15:0]       exp_sw;

    recorder_trigger_and_status dut (.pclk, .presetn, .apb_req, .apb_rsp, .acq_cycle,
        .trig_param_a, .trig_param_b, .block_written, .card_full, .error_code, .fill_level,
        .status_word, .combined_trigger, .logging_active, .irq);
    rec_backplane bp (.pclk, .presetn, .run, .switch_pin, .raw_a, .raw_b, .acq_cycle,
        .block_written, .trig_param_a, .trig_param_b);

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
        int k;
        k = 0;
        apb_req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: wd};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (apb_rsp.pready !== 1'b1 && k < 20);
        if (k >= 20) fail_count++;
        rd = apb_rsp.prdata;
        er = apb_rsp.pslverr;
        apb_req.psel    <= 1'b0;
        apb_req.penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Reference unit result from the shadow configuration
    function automatic logic unit_ok(input int u, input param_word_t p);
        logic [31:0] c;
        param_word_t m;
        c = ctrl >> (CTRL_UNIT_STRIDE * u);
        m = ~(p ^ msk[u][31:16]) & msk[u][15:0];
        if (!c[CTRL_EN_BIT]) return 1'b1;
        if (c[CTRL_ANALOG_BIT]) return p >= bnd[u][15:0] && p <= bnd[u][31:16];
        if (c[CTRL_OR_BIT]) return msk[u][15:0] == 0 || m != 0;
        return m == msk[u][15:0];
    endfunction

    function automatic logic comb_now();
        return (ctrl & 'h101) != 0 && unit_ok(0, trig_param_a) && unit_ok(1, trig_param_b);
    endfunction

    // Reference state: 0 idle, 1 logging, 2 full
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {st, cnt, irq_st} = '0;
            {rec_ok, comb_q, pend} = '0;
        end else begin
            if (pend) begin
                check("combined_trigger", comb_q, combined_trigger);
                check("status_word", exp_sw, status_word);
            end
            check("logging_active", st == 1, logging_active);
            pend = acq_cycle;
            if (acq_cycle) exp_sw = {fill_level, st == 0, st == 1 && rec_ok, st == 2, error_code};
            nxt = st;
            if (st == 0 && acq_cycle) nxt = card_full ? 2 : int'(comb_now());
            else if (st == 1 && card_full) nxt = 2;
            else if (st == 1 && block_written) begin
                cnt++;
                rec_ok = 1'b1;
                if (cnt >= 2) begin
                    cnt = 0;
                    if (!comb_q) nxt = 0;
                end
            end else if (st == 2 && !card_full) nxt = 0;
            if (acq_cycle) comb_q = comb_now();
            if (nxt != st) begin
                irq_st |= nxt == 1 ? 1 : nxt == 2 ? 4 : st == 1 ? 2 : 0;
                cnt = 0;
                rec_ok = 1'b0;
            end
            st = nxt;
        end
    end

    always @(posedge pclk) begin
        raw_a      <= param_word_t'($urandom % 2 ? ($urandom & 'hFF0F) | 'h0050 : $urandom);
        raw_b      <= param_word_t'($urandom);
        switch_pin <= 1'($urandom % 2);
        error_code <= ERR_W'($urandom);
        fill_level <= FILL_W'($urandom);
    end

    initial begin
        #50000;
        fail_count++;
        report_and_stop();
    end

    initial begin
        void'($urandom(77153));
        {presetn, run, card_full, switch_pin, ctrl} = '0;
        {apb_req, raw_a, raw_b, error_code, fill_level} = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (i = 0; i < 11; i++) begin
            apb(1'b0, ADDR_W'(4 * i), '0);
            check("reg_reset", rst_val[i], rd);
            check("pslverr", i == 10, er);
        end
        apb(1'b1, 8'h28, 32'h5);
        apb(1'b1, OFS_STATUS, 32'hFFFF);
        apb(1'b0, OFS_STATUS, '0);
        check("status_ro", 32'h0100, rd);
        apb(1'b1, OFS_BOUNDS_A, bnd[0]);
        apb(1'b1, OFS_MASK_A, msk[0]);
        apb(1'b1, OFS_BOUNDS_B, bnd[1]);
        apb(1'b1, OFS_MASK_B, msk[1]);
        apb(1'b1, OFS_BLOCKS, 32'h1);
        for (i = 0; i < 6; i++) begin
            apb(1'b1, OFS_IRQ_ENABLE, 32'h7);
            apb(1'b1, OFS_CTRL, ctrls[i]);
            ctrl = ctrls[i];
            run <= 1'b1;
            repeat (100) @(posedge pclk);
            card_full <= i == 4;
            repeat (40) @(posedge pclk);
            card_full <= 1'b0;
            repeat (100) @(posedge pclk);
            run <= 1'b0;
            repeat (8) @(posedge pclk);
            apb(1'b0, OFS_IRQ_STATUS, '0);
            check("irq_status", irq_st, rd);
            check("irq", irq_st != 0, irq);
            apb(1'b1, OFS_IRQ_ENABLE, '0);
            apb(1'b0, OFS_IRQ_ENABLE, '0);
            check("irq_masked", 0, irq);
            apb(1'b1, OFS_IRQ_CLEAR, 32'h7);
            irq_st = 0;
            apb(1'b0, OFS_IRQ_STATUS, '0);
            check("irq_cleared", 0, rd);
        end
        report_and_stop();
    end
endmodule

bind recorder_trigger_and_status rec_checker chk (.pclk, .presetn, .apb_req, .apb_rsp,
    .acq_cycle, .trig_param_a, .trig_param_b, .block_written, .card_full, .error_code,
    .fill_level, .status_word, .combined_trigger, .logging_active, .irq);
`default_nettype wire
